//--- verilog/mdad_alarm.sv
// alarm detection, latching, excitation control and register slave
//
// Contract
// [RULE_01] linked data with mixed directions raises code 70h
// [RULE_02] five or more linked entries raise code 70h
// [RULE_03] positioning start at speed zero raises code 70h
// [RULE_04] push-motion start above 500 r/min raises code 70h
// [RULE_05] resolution outside 100..10000 raises code 71h
// [RULE_06] wrap range inconsistent with resolution raises 72h, seven blinks (no blink output is driven; WRAP_BLINKS is unused)
// [RULE_07] master disconnect while motor runs raises code 81h
// [RULE_08] out-of-range rate switch setting raises code 83h
// [RULE_09] consecutive link errors reaching threshold raise code 84h
// [RULE_10] no master contact within timeout raises code 85h
// [RULE_11] network converter alarm raises code 8Eh
// [RULE_12] excitation-off alarms cut current and apply the brake
// [RULE_13] excitation-on alarms keep current flowing
// [RULE_14] resettable alarms clear on falling edge of the clear input
// [RULE_15] active alarm code stays readable until cleared
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module mdad_alarm #(
   parameter int MS_CYC = mdad_pkg::MS_CYCLES
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic OP_START_I,
   input wire logic OP_PUSH_I,
   input wire logic [3:0] OP_LINKS_I,
   input wire logic OP_DIR_MIXED_I,
   input wire logic [15:0] OP_SPEED_I,
   input wire logic MOTOR_RUN_I,
   input wire logic LINK_OK_I,
   input wire logic LINK_ERR_I,
   input wire logic NET_DISC_I,
   input wire logic CONV_ALARM_I,
   input wire logic ALARM_CLEAR_INPUT_I,
   input wire logic [3:0] RATE_SELECT_SWITCH_I,
   output logic ALARM_O,
   output logic [7:0] ALARM_CODE_O,
   output logic EXCITE_O,
   output logic BRAKE_O,
   output logic IRQ_O
);
   function automatic logic [7:0] code_of(input logic [2:0] i);
      case (i)
         mdad_pkg::I_OPDATA: code_of = mdad_pkg::C_OPDATA;
         mdad_pkg::I_GEAR: code_of = mdad_pkg::C_GEAR;
         mdad_pkg::I_WRAP: code_of = mdad_pkg::C_WRAP;
         mdad_pkg::I_NETBUS: code_of = mdad_pkg::C_NETBUS;
         mdad_pkg::I_RATE: code_of = mdad_pkg::C_RATE;
         mdad_pkg::I_LINKERR: code_of = mdad_pkg::C_LINKERR;
         mdad_pkg::I_TIMEOUT: code_of = mdad_pkg::C_TIMEOUT;
         default: code_of = mdad_pkg::C_CONV;
      endcase
   endfunction : code_of

   // excitation-on alarms are also the resettable ones
   function automatic logic exc_on(input logic [2:0] i);
      exc_on = !(i == mdad_pkg::I_GEAR || i == mdad_pkg::I_WRAP ||
                 i == mdad_pkg::I_RATE);
   endfunction : exc_on

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] be);
      merge = o;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            merge[b*8 +: 8] = n[b*8 +: 8];
         end
      end
   endfunction : merge

   mdad_pkg::mdad_state_t q, d;
   logic [7:0] ev;
   logic [2:0] first;
   logic clr_fall;
   logic req;
   logic [31:0] rd;
   logic [31:0] wv;
   logic link_done;

   assign req = AVS_READ_I | AVS_WRITE_I;
   assign clr_fall = q.clr_prev & !q.s2[2];
   assign link_done = q.tmo_lim != 16'h0000 && q.ms_cnt >= q.tmo_lim;

   always_comb begin
      ev = 8'h00;
      ev[mdad_pkg::I_OPDATA] = OP_START_I && (OP_DIR_MIXED_I // RULE_01
         || OP_LINKS_I > mdad_pkg::LINK_MAX // RULE_02
         || (!OP_PUSH_I && OP_SPEED_I == 16'h0000) // RULE_03
         || (OP_PUSH_I && OP_SPEED_I > mdad_pkg::PUSH_SPD_MAX)); // RULE_04
      ev[mdad_pkg::I_GEAR] = q.ctrl_en && (q.res < mdad_pkg::RES_MIN
         || q.res > mdad_pkg::RES_MAX); // RULE_05
      // a wrap range below one revolution cannot be represented
      ev[mdad_pkg::I_WRAP] = q.ctrl_en && q.wrap_en
         && (q.wrap_rng == 16'h0000 || q.wrap_rng < q.res); // RULE_06
      ev[mdad_pkg::I_NETBUS] = MOTOR_RUN_I && q.s2[0]; // RULE_07
      ev[mdad_pkg::I_RATE] = q.s2[6:3] > mdad_pkg::RATE_MAX; // RULE_08
      ev[mdad_pkg::I_LINKERR] = LINK_ERR_I && !LINK_OK_I
         && q.err_lim != 8'h00
         && q.err_cnt + 8'h01 >= q.err_lim; // RULE_09
      ev[mdad_pkg::I_TIMEOUT] = link_done && !LINK_OK_I; // RULE_10
      ev[mdad_pkg::I_CONV] = q.s2[1]; // RULE_11
      first = 3'h0;
      for (int i = mdad_pkg::NALM - 1; i >= 0; i--) begin
         if (ev[i]) begin
            first = 3'(i);
         end
      end
   end

   always_comb begin
      rd = 32'h0000_0000;
      case (AVS_ADDRESS_I)
         mdad_pkg::OFS_CTRL: rd[mdad_pkg::CTRL_EN_BIT] = q.ctrl_en;
         mdad_pkg::OFS_STATUS: rd[7:0] = q.status;
         mdad_pkg::OFS_MASK: rd[7:0] = q.mask;
         mdad_pkg::OFS_CODE: begin
            rd[7:0] = q.alm_act ? code_of(q.alm_idx) : 8'h00; // RULE_15
            rd[mdad_pkg::CODE_ACT_BIT] = q.alm_act;
         end
         mdad_pkg::OFS_RES: rd[15:0] = q.res;
         mdad_pkg::OFS_WRAP: begin
            rd[15:0] = q.wrap_rng;
            rd[mdad_pkg::WRAP_EN_BIT] = q.wrap_en;
         end
         mdad_pkg::OFS_ERRLIM: rd[7:0] = q.err_lim;
         mdad_pkg::OFS_TMO: rd[15:0] = q.tmo_lim;
         mdad_pkg::OFS_ERRCNT: rd[7:0] = q.err_cnt;
         default: rd = 32'h0000_0000;
      endcase
   end

   always_comb begin
      d = q;
      d.s1 = {RATE_SELECT_SWITCH_I, ALARM_CLEAR_INPUT_I, CONV_ALARM_I,
              NET_DISC_I};
      d.s2 = q.s1;
      d.clr_prev = q.s2[2];
      // one wait cycle per access; readdata lands with waitrequest low
      d.ack = req && !q.ack;
      if (req && !q.ack) begin
         d.rdata = AVS_READ_I ? rd : q.rdata;
      end
      // merged write word; a function result cannot be sliced directly
      wv = 32'h0000_0000;
      if (AVS_WRITE_I && q.ack) begin
         case (AVS_ADDRESS_I)
            mdad_pkg::OFS_CTRL: begin
               wv = merge({31'h0, q.ctrl_en}, AVS_WRITEDATA_I,
                          AVS_BYTEENABLE_I);
               d.ctrl_en = wv[mdad_pkg::CTRL_EN_BIT];
            end
            mdad_pkg::OFS_STATUS:
               if (AVS_BYTEENABLE_I[0]) begin
                  d.status = q.status & ~AVS_WRITEDATA_I[7:0];
               end
            mdad_pkg::OFS_MASK: begin
               wv = merge({24'h0, q.mask}, AVS_WRITEDATA_I,
                          AVS_BYTEENABLE_I);
               d.mask = wv[7:0];
            end
            mdad_pkg::OFS_RES: begin
               wv = merge({16'h0, q.res}, AVS_WRITEDATA_I,
                          AVS_BYTEENABLE_I);
               d.res = wv[15:0];
            end
            mdad_pkg::OFS_WRAP: begin
               wv = merge({q.wrap_en, 15'h0, q.wrap_rng},
                          AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
               d.wrap_en = wv[mdad_pkg::WRAP_EN_BIT];
               d.wrap_rng = wv[15:0];
            end
            mdad_pkg::OFS_ERRLIM: begin
               wv = merge({24'h0, q.err_lim}, AVS_WRITEDATA_I,
                          AVS_BYTEENABLE_I);
               d.err_lim = wv[7:0];
            end
            mdad_pkg::OFS_TMO: begin
               wv = merge({16'h0, q.tmo_lim}, AVS_WRITEDATA_I,
                          AVS_BYTEENABLE_I);
               d.tmo_lim = wv[15:0];
            end
            default: d.ctrl_en = q.ctrl_en;
         endcase
      end
      // new events set status after the clear so a same-cycle event wins
      d.status = d.status | ev;
      // consecutive error count; any good frame restarts it
      if (LINK_OK_I) begin
         d.err_cnt = 8'h00;
      end else if (LINK_ERR_I && q.err_cnt != 8'hff) begin // RULE_09
         d.err_cnt = q.err_cnt + 8'h01;
      end
      // timeout counts whole milliseconds since the last good frame
      if (LINK_OK_I || q.tmo_lim == 16'h0000) begin
         d.ms_cyc = 17'h0;
         d.ms_cnt = 16'h0;
      end else if (!link_done) begin // RULE_10
         if (q.ms_cyc == 17'(MS_CYC - 1)) begin
            d.ms_cyc = 17'h0;
            d.ms_cnt = q.ms_cnt + 16'h0001;
         end else begin
            d.ms_cyc = q.ms_cyc + 17'h1;
         end
      end
      // power-cycle alarms ignore the clear input
      if (q.alm_act && clr_fall && exc_on(q.alm_idx)) begin // RULE_14
         d.alm_act = 1'b0;
         d.err_cnt = 8'h00;
         d.ms_cyc = 17'h0;
         d.ms_cnt = 16'h0;
      end
      // first alarm is kept so its cause is not overwritten
      if (!d.alm_act && |ev) begin // RULE_15
         d.alm_act = 1'b1;
         d.alm_idx = first;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         q <= '0;
         q.res <= mdad_pkg::RES_RST;
         q.wrap_rng <= mdad_pkg::WRAP_RNG_RST;
         q.err_lim <= mdad_pkg::ERRLIM_RST;
         q.tmo_lim <= mdad_pkg::TMO_RST;
      end else begin
         q <= d;
      end
   end

   assign AVS_WAITREQUEST_O = req && !q.ack;
   assign AVS_READDATA_O = q.rdata;
   assign ALARM_O = q.alm_act;
   assign ALARM_CODE_O = q.alm_act ? code_of(q.alm_idx) : 8'h00;
   assign EXCITE_O = !q.alm_act || exc_on(q.alm_idx); // RULE_12 RULE_13
   assign BRAKE_O = q.alm_act && !exc_on(q.alm_idx); // RULE_12
   assign IRQ_O = |(q.status & q.mask);

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   property p_dir;
      OP_START_I && OP_DIR_MIXED_I && !q.alm_act
         |=> ALARM_O && ALARM_CODE_O == 8'h70;
   endproperty
   a_dir: assert property (p_dir) else $error("mixed dir no 70h"); // RULE_01

   property p_links;
      OP_START_I && OP_LINKS_I >= 4'h5 |=> q.status[0];
   endproperty
   a_links: assert property (p_links) else $error("links no 70h"); // RULE_02

   property p_zero;
      OP_START_I && !OP_PUSH_I && OP_SPEED_I == 16'h0 && !q.alm_act
         |=> ALARM_CODE_O == 8'h70;
   endproperty
   a_zero: assert property (p_zero) else $error("speed 0 no 70h"); // RULE_03

   property p_push;
      OP_START_I && OP_PUSH_I && OP_SPEED_I == 16'd501
         |=> q.status[0] && ALARM_O;
   endproperty
   a_push: assert property (p_push) else $error("push speed no 70h"); // RULE_04

   property p_gear;
      q.ctrl_en && q.res == 16'd99 && !OP_START_I && !q.alm_act
         |=> ALARM_CODE_O == 8'h71 ##1 ALARM_O;
   endproperty
   a_gear: assert property (p_gear) else $error("gear no 71h"); // RULE_05

   property p_off;
      ALARM_O && (ALARM_CODE_O == 8'h71 || ALARM_CODE_O == 8'h83)
         |-> !EXCITE_O && BRAKE_O;
   endproperty
   a_off: assert property (p_off) else $error("off class excites"); // RULE_12

   property p_on;
      ALARM_O && ALARM_CODE_O == 8'h84 |-> EXCITE_O && !BRAKE_O;
   endproperty
   a_on: assert property (p_on) else $error("on class not excited"); // RULE_13

   property p_clr;
      ALARM_O && ALARM_CODE_O == 8'h85 && clr_fall && ev == 8'h00
         |=> !ALARM_O;
   endproperty
   a_clr: assert property (p_clr) else $error("clear ignored"); // RULE_14

   property p_hold;
      ALARM_O && !clr_fall |=> ALARM_O && $stable(ALARM_CODE_O);
   endproperty
   a_hold: assert property (p_hold) else $error("code changed"); // RULE_15

   property p_conv;
      CONV_ALARM_I ##1 CONV_ALARM_I |=> ##1 q.status[7];
   endproperty
   a_conv: assert property (p_conv) else $error("conv no 8eh"); // RULE_11
endmodule : mdad_alarm

//--- verilog/mdad_pkg.sv
// constants and state type of the motor driver alarm detector
package mdad_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_CODE = 8'h0c;
   localparam logic [7:0] OFS_RES = 8'h10;
   localparam logic [7:0] OFS_WRAP = 8'h14;
   localparam logic [7:0] OFS_ERRLIM = 8'h18;
   localparam logic [7:0] OFS_TMO = 8'h1c;
   localparam logic [7:0] OFS_ERRCNT = 8'h20;
   // field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int WRAP_EN_BIT = 31;
   localparam int CODE_ACT_BIT = 8;
   // reset values
   localparam logic [15:0] RES_RST = 16'h03e8;
   localparam logic [15:0] WRAP_RNG_RST = 16'h03e8;
   localparam logic [7:0] ERRLIM_RST = 8'h03;
   localparam logic [15:0] TMO_RST = 16'h0000;
   // limits
   localparam logic [15:0] RES_MIN = 16'h0064;
   localparam logic [15:0] RES_MAX = 16'h2710;
   localparam logic [15:0] PUSH_SPD_MAX = 16'h01f4;
   localparam logic [3:0] LINK_MAX = 4'h4;
   localparam logic [3:0] RATE_MAX = 4'h4;
   // alarm codes, index order is also priority order
   localparam int NALM = 8;
   localparam logic [7:0] C_OPDATA = 8'h70;
   localparam logic [7:0] C_GEAR = 8'h71;
   localparam logic [7:0] C_WRAP = 8'h72;
   localparam logic [7:0] C_NETBUS = 8'h81;
   localparam logic [7:0] C_RATE = 8'h83;
   localparam logic [7:0] C_LINKERR = 8'h84;
   localparam logic [7:0] C_TIMEOUT = 8'h85;
   localparam logic [7:0] C_CONV = 8'h8e;
   localparam logic [2:0] I_OPDATA = 3'h0;
   localparam logic [2:0] I_GEAR = 3'h1;
   localparam logic [2:0] I_WRAP = 3'h2;
   localparam logic [2:0] I_NETBUS = 3'h3;
   localparam logic [2:0] I_RATE = 3'h4;
   localparam logic [2:0] I_LINKERR = 3'h5;
   localparam logic [2:0] I_TIMEOUT = 3'h6;
   localparam logic [2:0] I_CONV = 3'h7;
   localparam int WRAP_BLINKS = 7;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic ctrl_en;
      logic [7:0] status;
      logic [7:0] mask;
      logic [15:0] res;
      logic wrap_en;
      logic [15:0] wrap_rng;
      logic [7:0] err_lim;
      logic [15:0] tmo_lim;
      logic [7:0] err_cnt;
      logic [16:0] ms_cyc;
      logic [15:0] ms_cnt;
      logic alm_act;
      logic [2:0] alm_idx;
      logic [6:0] s1;
      logic [6:0] s2;
      logic clr_prev;
   } mdad_state_t;
endpackage : mdad_pkg

//--- testbench/mdad_master_model.sv
// master controller side: serial frames, disconnect and alarm clear
`timescale 1ns/1ps
module mdad_master_model (
   input wire logic clk_i,
   output logic link_ok_o,
   output logic link_err_o,
   output logic net_disc_o,
   output logic clear_o
);
   initial begin
      link_ok_o = 1'b0;
      link_err_o = 1'b0;
      net_disc_o = 1'b0;
      clear_o = 1'b0;
   end
   // one frame outcome as a single-cycle pulse, then at least one idle cycle
   task automatic frame(input logic good, input int gap);
      link_ok_o <= good;
      link_err_o <= !good;
      @(posedge clk_i);
      link_ok_o <= 1'b0;
      link_err_o <= 1'b0;
      repeat (gap + 1) @(posedge clk_i);
   endtask : frame
   task automatic disconnect(input int len);
      net_disc_o <= 1'b1;
      repeat (len) @(posedge clk_i);
      net_disc_o <= 1'b0;
      @(posedge clk_i);
   endtask : disconnect
   // held high well past the input synchroniser before the falling edge
   task automatic clear_alarm();
      clear_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      clear_o <= 1'b0;
      @(posedge clk_i);
   endtask : clear_alarm
endmodule : mdad_master_model

//--- testbench/motor_driver_alarm_detect_test.sv
// self-checking bench for the motor driver alarm detector
`timescale 1ns/1ps
module motor_driver_alarm_detect_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic start = 1'b0;
   logic push = 1'b0;
   logic [3:0] links = 4'h1;
   logic mixed = 1'b0;
   logic [15:0] speed = 16'h0064;
   logic run = 1'b0;
   logic conv = 1'b0;
   logic [3:0] rate = 4'h0;
   logic [31:0] rdata;
   logic [31:0] v;
   logic [7:0] code;
   logic waitreq, ok, err, disc, clr, alarm, excite, brake, irq;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;

   always #4 clk = ~clk;

   mdad_master_model i_mdad_master_model (.clk_i(clk), .link_ok_o(ok),
      .link_err_o(err), .net_disc_o(disc), .clear_o(clr));

   mdad_alarm #(.MS_CYC(10)) i_mdad_alarm (.CLK_I(clk), .RST_I(rst),
      .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en),
      .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
      .OP_START_I(start), .OP_PUSH_I(push), .OP_LINKS_I(links),
      .OP_DIR_MIXED_I(mixed), .OP_SPEED_I(speed), .MOTOR_RUN_I(run),
      .LINK_OK_I(ok), .LINK_ERR_I(err), .NET_DISC_I(disc),
      .CONV_ALARM_I(conv), .ALARM_CLEAR_INPUT_I(clr),
      .RATE_SELECT_SWITCH_I(rate), .ALARM_O(alarm), .ALARM_CODE_O(code),
      .EXCITE_O(excite), .BRAKE_O(brake), .IRQ_O(irq));

   task automatic report_and_stop();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      addr <= a;
      wdata <= d;
      rd_en <= !w;
      wr_en <= w;
      // no local limit: a slave that never answers ends in the run timeout
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      v = rdata;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic op(input logic p, input logic [3:0] l, input logic m,
                     input logic [15:0] s);
      push <= p;
      links <= l;
      mixed <= m;
      speed <= s;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask : op

   task automatic wait_alm(input logic exp);
      int n;
      n = 0;
      while (alarm !== exp && n < 60) begin
         @(posedge clk);
         n++;
      end
      chk(alarm, exp);
   endtask : wait_alm

   task automatic resettable(input logic [7:0] c);
      wait_alm(1'b1);
      chk(code, c);
      chk({excite, brake}, 2'b10);
      bus(1'b0, mdad_pkg::OFS_CODE, 0);
      chk(v, {23'h0, 1'b1, c});
      i_mdad_master_model.clear_alarm();
      wait_alm(1'b0);
      chk(code, 8'h00);
      bus(1'b1, mdad_pkg::OFS_STATUS, 32'hff);
   endtask : resettable

   // excitation-off alarms ignore the clear input and need a reset
   task automatic hard_alarm(input logic [7:0] c);
      wait_alm(1'b1);
      chk(code, c);
      chk({excite, brake}, 2'b01);
      i_mdad_master_model.clear_alarm();
      repeat (4) @(posedge clk);
      chk(alarm, 1'b1);
      rate <= 4'h0;
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(alarm, 1'b0);
   endtask : hard_alarm

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({excite, brake, alarm, irq}, 4'b1000);
      bus(1'b0, mdad_pkg::OFS_RES, 0);
      chk(v, 32'h3e8);
      bus(1'b1, 8'h24, 32'hffffffff);
      bus(1'b0, 8'h24, 0);
      chk(v, 32'h0);
      bus(1'b1, mdad_pkg::OFS_MASK, 32'h1);
      op(1'b1, 4'h1, 1'b0, 16'h01f4);
      repeat (3) @(posedge clk);
      chk(alarm, 1'b0);
      op(1'b1, 4'h1, 1'b0, 16'h01f5);
      wait_alm(1'b1);
      chk(irq, 1'b1);
      bus(1'b0, mdad_pkg::OFS_STATUS, 0);
      chk(v, 32'h1);
      resettable(8'h70);
      chk(irq, 1'b0);
      op(1'b0, 4'h2, 1'b1, 16'h0064);
      resettable(8'h70);
      op(1'b0, 4'h5, 1'b0, 16'h0064);
      resettable(8'h70);
      op(1'b0, 4'h1, 1'b0, 16'h0000);
      resettable(8'h70);
      // a good frame breaks the run of consecutive errors
      i_mdad_master_model.frame(1'b0, 1);
      i_mdad_master_model.frame(1'b0, 1);
      i_mdad_master_model.frame(1'b1, 1);
      i_mdad_master_model.frame(1'b0, 1);
      i_mdad_master_model.frame(1'b0, 1);
      bus(1'b0, mdad_pkg::OFS_ERRCNT, 0);
      chk(v, 32'h2);
      chk(alarm, 1'b0);
      i_mdad_master_model.frame(1'b0, 1);
      resettable(8'h84);
      bus(1'b1, mdad_pkg::OFS_TMO, 32'h2);
      repeat (6) i_mdad_master_model.frame(1'b1, 7);
      chk(alarm, 1'b0);
      wait_alm(1'b1);
      bus(1'b1, mdad_pkg::OFS_TMO, 32'h0);
      resettable(8'h85);
      i_mdad_master_model.disconnect(6);
      repeat (4) @(posedge clk);
      chk(alarm, 1'b0);
      run <= 1'b1;
      i_mdad_master_model.disconnect(6);
      resettable(8'h81);
      run <= 1'b0;
      conv <= 1'b1;
      repeat (6) @(posedge clk);
      conv <= 1'b0;
      resettable(8'h8e);
      bus(1'b1, mdad_pkg::OFS_RES, 32'h64);
      bus(1'b1, mdad_pkg::OFS_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      chk(alarm, 1'b0);
      bus(1'b1, mdad_pkg::OFS_RES, 32'h63);
      hard_alarm(8'h71);
      bus(1'b1, mdad_pkg::OFS_WRAP, 32'h800003e7);
      bus(1'b1, mdad_pkg::OFS_CTRL, 32'h1);
      hard_alarm(8'h72);
      rate <= 4'h5;
      hard_alarm(8'h83);
      report_and_stop();
   end
endmodule : motor_driver_alarm_detect_test
